// ### rtl/shsc_pkg.sv
/*
 Shared constants and the command frame type of the switch control block.
 Assumes one 25 MHz system clock and an 8-bit serial frame, MSB first.
*/
package shsc_pkg;
   // ==========================================================
   // Frame and channel sizes
   localparam int FRAME_BITS = 8;
   localparam int CH_NUM = 5;
   localparam logic [3:0] FRAME_BITS_CNT = 4'h8;

   // ==========================================================
   // Bank 1 register addresses
   localparam logic [1:0] ADDR_HW_CONFIG = 2'b10;
   localparam logic [1:0] ADDR_INPUT_COMB = 2'b01;
   localparam logic [1:0] ADDR_SENSE_SEL = 2'b11;

   // ==========================================================
   // Field positions
   localparam int HW_RESET_CMD_BIT = 1;
   localparam int HW_STANDBY_BIT = 1;
   localparam int HW_CONTROL_BIT = 0;
   localparam int COMB_MODE_BIT = 3;

   // ==========================================================
   // Reset values
   localparam logic [4:0] OUT_RST = 5'h00;
   localparam logic CONTROL_RST = 1'b0;
   localparam logic COMB_MODE_RST = 1'b0;
   localparam logic [2:0] SENSE_SEL_RST = 3'h7;

   // ==========================================================
   // Command frame as received: direction, bank, address, data
   typedef struct packed {
      logic wr;
      logic rb;
      logic [1:0] addr;
      logic [3:0] data;
   } shsc_frame_t;
endpackage

// ### rtl/shsc_top.sv
/*
 Serial-controlled register bank and input switch matrix of a five-channel
 high-side switch. Assumes all pins are synchronous to CLK_SYS_I and that
 the serial clock runs well below a quarter of the system clock.
*/
// Behaviour
// - A frame is direction, bank, two address bits and data; bank 1 address 10 is the hardware configuration register whose bits 3 and 2 are written as 0.
// - Writing 1 to bit 1 of the hardware configuration register fires the reset command; 0 keeps normal operation.
// - Reading the hardware configuration register gives stand-by in bit 1, the control bit in bit 0 and 0 in bit 3.
// - There are five channels, each with its own input pin and its own output register bit.
// - Each channel can be switched on by its pin or by its register bit as the combination mode allows.
// - With combination mode 0 a channel is on when its register bit or its pin is high.
// - With combination mode 1 a channel is on only while both its register bit and its pin are high.
// - An open input pin counts as low and never switches a channel on alone.
// - The reset command restores all register bits and flags like power-on reset; the channel flops are not reset but follow the cleared register bits and the pins.
// - The first transfer after any reset returns the output register with the transmission error flag set.
// - Stand-by is entered while the current sense select is 111, clearing thermal latches and setting stand-by status.
`timescale 1ns/10ps
`default_nettype none
module shsc_top (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   // Serial port
   input wire logic SPI_CSN_I,
   input wire logic SPI_SCLK_I,
   input wire logic SPI_SI_I,
   output logic SPI_SO_O,
   output logic SPI_SO_OEN_O,
   // Channels
   input wire logic [shsc_pkg::CH_NUM-1:0] CH_IN_I,
   output logic [shsc_pkg::CH_NUM-1:0] CH_OUT_O,
   // Status
   output logic STANDBY_O,
   output logic CONTROL_BIT_O,
   output logic THERM_CLR_O
);
   // ==========================================================
   // Serial edge detection
   logic csn_q;
   logic sclk_q;
   logic [7:0] rx_q;
   logic [3:0] cnt_q;
   logic [7:0] tx_q;
   logic oen_q;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;

   assign cs_fall = csn_q & ~SPI_CSN_I;
   assign cs_rise = ~csn_q & SPI_CSN_I;
   assign sck_rise = ~sclk_q & SPI_SCLK_I & ~SPI_CSN_I;
   assign sck_fall = sclk_q & ~SPI_SCLK_I & ~SPI_CSN_I;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         csn_q <= 1'b1;
         sclk_q <= 1'b0;
      end else begin
         csn_q <= SPI_CSN_I;
         sclk_q <= SPI_SCLK_I;
      end
   end

   // ==========================================================
   // Frame decode
   shsc_pkg::shsc_frame_t frame;
   logic frame_ok;
   logic wr_ok;
   logic hw_wr;
   logic hw_bad;
   logic soft_rst;
   logic clr;

   assign frame = shsc_pkg::shsc_frame_t'(rx_q);
   assign frame_ok = cs_rise && (cnt_q == shsc_pkg::FRAME_BITS_CNT);
   assign wr_ok = frame_ok & frame.wr;
   // Writes with bits 3..2 set are refused, not half executed
   assign hw_wr = wr_ok & frame.rb & (frame.addr == shsc_pkg::ADDR_HW_CONFIG);
   assign hw_bad = hw_wr & (frame.data[3:2] != 2'b00);
   assign soft_rst = hw_wr & ~hw_bad & frame.data[shsc_pkg::HW_RESET_CMD_BIT];
   assign clr = !RESETN_I | soft_rst;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I || cs_fall) begin
         rx_q <= 8'h00;
         cnt_q <= 4'h0;
      end else if (sck_rise) begin
         rx_q <= {rx_q[6:0], SPI_SI_I};
         // Saturate so overlong frames stay detectable
         if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end

   // ==========================================================
   // Registers
   logic [shsc_pkg::CH_NUM-1:0] out_q;
   logic comb_q;
   logic ctl_q;
   logic [2:0] sense_q;
   logic standby_q;
   logic therm_clr_q;
   logic ter_q;
   logic sel_rb_q;
   logic [1:0] sel_addr_q;

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         out_q <= shsc_pkg::OUT_RST;
      end else if (wr_ok && !frame.rb) begin
         // Bit 5 of the frame is written as 0 and not stored
         out_q <= {frame.addr[0], frame.data};
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         comb_q <= shsc_pkg::COMB_MODE_RST;
      end else if (wr_ok && frame.rb && frame.addr == shsc_pkg::ADDR_INPUT_COMB) begin
         comb_q <= frame.data[shsc_pkg::COMB_MODE_BIT];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         ctl_q <= shsc_pkg::CONTROL_RST;
      end else if (hw_wr && !hw_bad) begin
         ctl_q <= frame.data[shsc_pkg::HW_CONTROL_BIT];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         sense_q <= shsc_pkg::SENSE_SEL_RST;
      end else if (wr_ok && frame.rb && frame.addr == shsc_pkg::ADDR_SENSE_SEL) begin
         sense_q <= frame.data[2:0];
      end
   end

   // Stand-by follows the select field; latch clear pulses on entry
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         standby_q <= 1'b1;
         therm_clr_q <= 1'b0;
      end else begin
         standby_q <= (sense_q == shsc_pkg::SENSE_SEL_RST);
         therm_clr_q <= (sense_q == shsc_pkg::SENSE_SEL_RST) & ~standby_q;
      end
   end

   // Error flag: set wins over the clear at frame end
   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         ter_q <= 1'b1;
      end else if (cs_rise) begin
         ter_q <= ~frame_ok | hw_bad;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (clr) begin
         sel_rb_q <= 1'b0;
         sel_addr_q <= 2'b00;
      end else if (frame_ok) begin
         sel_rb_q <= frame.rb;
         sel_addr_q <= frame.addr;
      end
   end

   // ==========================================================
   // Answer word for the next frame
   function automatic logic [7:0] answer(input logic rb, input logic [1:0] addr);
      logic [3:0] d;
      d = 4'h0;
      unique case (addr)
         shsc_pkg::ADDR_HW_CONFIG: d = {2'b00, standby_q, ctl_q};
         shsc_pkg::ADDR_INPUT_COMB: d = {comb_q, 3'b000};
         shsc_pkg::ADDR_SENSE_SEL: d = {1'b0, sense_q};
         default: d = 4'h0;
      endcase
      if (rb) begin
         answer = {ter_q, 1'b1, addr, d};
      end else begin
         answer = {ter_q, 2'b00, out_q};
      end
   endfunction

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         tx_q <= 8'h00;
         oen_q <= 1'b1;
      end else begin
         oen_q <= SPI_CSN_I;
         if (cs_fall) begin
            tx_q <= answer(sel_rb_q, sel_addr_q);
         end else if (sck_fall) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end

   // ==========================================================
   // Input switch matrix; not touched by the reset command
   logic [shsc_pkg::CH_NUM-1:0] ch_q;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         ch_q <= '0;
      end else if (comb_q) begin
         ch_q <= out_q & CH_IN_I;
      end else begin
         // Open pins are pulled low outside, so a low pin adds nothing
         ch_q <= out_q | CH_IN_I;
      end
   end

   assign CH_OUT_O = ch_q;
   assign SPI_SO_O = tx_q[7];
   assign SPI_SO_OEN_O = oen_q;
   assign STANDBY_O = standby_q;
   assign CONTROL_BIT_O = ctl_q;
   assign THERM_CLR_O = therm_clr_q;
endmodule
`default_nettype wire

// ### tb/shsc_top_properties.sv
/* Port checker for shsc_top; bound below, one clock, sync reset. */
`timescale 1ns/10ps
`default_nettype none
module shsc_top_properties (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESETN_I,
   // Serial port
   input wire logic SPI_CSN_I,
   input wire logic SPI_SCLK_I,
   input wire logic SPI_SI_I,
   input wire logic SPI_SO_O,
   input wire logic SPI_SO_OEN_O,
   // Channels and status
   input wire logic [shsc_pkg::CH_NUM-1:0] CH_IN_I,
   input wire logic [shsc_pkg::CH_NUM-1:0] CH_OUT_O,
   input wire logic STANDBY_O,
   input wire logic CONTROL_BIT_O,
   input wire logic THERM_CLR_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   property p_rst; $rose(RESETN_I) |-> !CH_OUT_O && STANDBY_O && !CONTROL_BIT_O; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_oen; $past(RESETN_I) |-> SPI_SO_OEN_O == $past(SPI_CSN_I); endproperty
   a_oen: assert property (p_oen) else $error("SO enable off");
   property p_tpl; THERM_CLR_O |=> !THERM_CLR_O; endproperty
   a_tpl: assert property (p_tpl) else $error("latch clear too long");
   property p_tsb; THERM_CLR_O |-> ##[0:2] STANDBY_O; endproperty
   a_tsb: assert property (p_tsb) else $error("latch clear awake");
   // Registers settle two clocks after a frame, so four idle samples
   property p_chh; $past(RESETN_I) && SPI_CSN_I && $past(SPI_CSN_I) && $past(SPI_CSN_I, 2)
      && $past(SPI_CSN_I, 3) && $stable(CH_IN_I) |=> $stable(CH_OUT_O); endproperty
   a_chh: assert property (p_chh) else $error("channel moved alone");
   property p_so; !SPI_CSN_I && !$past(SPI_CSN_I, 2) && !$past(SPI_CSN_I, 4) && SPI_SCLK_I
      && $past(SPI_SCLK_I) && $past(SPI_SCLK_I, 2) |-> $stable(SPI_SO_O); endproperty
   a_so: assert property (p_so) else $error("SO moved with SCLK high");
   property p_ctl; $past(RESETN_I) && $changed(CONTROL_BIT_O) |-> ($past(SPI_CSN_I) &&
      !$past(SPI_CSN_I, 2)) || ($past(SPI_CSN_I, 2) && !$past(SPI_CSN_I, 3)); endproperty
   a_ctl: assert property (p_ctl) else $error("control bit moved");
   property p_stb; $past(RESETN_I) && $changed(STANDBY_O) |-> ($past(SPI_CSN_I) &&
      !$past(SPI_CSN_I, 2)) || ($past(SPI_CSN_I, 2) && !$past(SPI_CSN_I, 3)) ||
      ($past(SPI_CSN_I, 3) && !$past(SPI_CSN_I, 4)); endproperty
   a_stb: assert property (p_stb) else $error("stand-by moved");
endmodule
bind shsc_top shsc_top_properties u_chk (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
   .SPI_CSN_I(SPI_CSN_I), .SPI_SCLK_I(SPI_SCLK_I), .SPI_SI_I(SPI_SI_I), .SPI_SO_O(SPI_SO_O),
   .SPI_SO_OEN_O(SPI_SO_OEN_O), .CH_IN_I(CH_IN_I), .CH_OUT_O(CH_OUT_O),
   .STANDBY_O(STANDBY_O), .CONTROL_BIT_O(CONTROL_BIT_O), .THERM_CLR_O(THERM_CLR_O));
`default_nettype wire

// ### tb/shsc_spi_master.sv
/* Serial master model; assumes the system clock for pacing. */
`timescale 1ns/10ps
`default_nettype none
module shsc_spi_master (
   input wire logic clk_i,
   input wire logic so_i,
   output logic csn_o,
   output logic sclk_o,
   output logic si_o
);
   initial begin
      csn_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end
   task automatic tick();
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // Fewer than eight bits only to provoke a length error
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      csn_o = 1'b0;
      tick();
      for (int i = 7; i > 7 - nb; i--) begin
         si_o = tx[i];
         tick();
         sclk_o = 1'b1;
         rx = {rx[6:0], so_i};
         tick();
         sclk_o = 1'b0;
      end
      tick();
      csn_o = 1'b1;
      si_o = ~si_o;
      tick();
   endtask
endmodule
`default_nettype wire

// ### tb/shsc_tb_top.sv
/* Self-checking bench of shsc_top; drives pins, frames via the master model. */
`timescale 1ns/10ps
`default_nettype none
module shsc_tb_top;
   logic clk, rstn, csn, sclk, si, so, oen, stb, ctl, md, thc;
   logic [4:0] chi, cho, r, p;
   logic [31:0] lfsr = 32'h30b0a3ab;
   logic [7:0] rx;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   int n_thc = 0;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   shsc_top uut (.CLK_SYS_I(clk), .RESETN_I(rstn), .SPI_CSN_I(csn), .SPI_SCLK_I(sclk),
      .SPI_SI_I(si), .SPI_SO_O(so), .SPI_SO_OEN_O(oen), .CH_IN_I(chi), .CH_OUT_O(cho),
      .STANDBY_O(stb), .CONTROL_BIT_O(ctl), .THERM_CLR_O(thc));
   // Released SO reads inverted, so a late output enable shows up as bad data
   shsc_spi_master m (.clk_i(clk), .so_i(oen ? ~so : so), .csn_o(csn), .sclk_o(sclk),
      .si_o(si));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [4:0] exp_ch(input logic m1, input logic [4:0] o, input logic [4:0] i);
      return m1 ? (o & i) : (o | i);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (thc === 1'b1) n_thc++;
      if (cyc > 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      rstn = 1'b0;
      chi = 5'h00;
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1 check({cho, stb, ctl, oen}, 8'h05);
      m.xfer(8'hd8, 8, rx);
      check(rx, 8'h80);
      m.xfer(8'he1, 8, rx);
      check(rx, 8'h58);
      m.xfer(8'hf0, 8, rx);
      check(rx, 8'h63);
      check({6'h00, stb, ctl}, 8'h01);
      m.xfer(8'he8, 8, rx);
      check(rx, 8'h70);
      m.xfer(8'h60, 8, rx);
      check({7'h00, ctl}, 8'h01);
      check(rx, 8'he1);
      m.xfer(8'h60, 7, rx);
      m.xfer(8'h60, 8, rx);
      check(rx, 8'he1);
      for (int k = 0; k < 12; k++) begin
         if (k == 6) m.xfer(8'hd0, 8, rx);
         md = (k < 6);
         lfsr = nxt(lfsr);
         r = (k == 0) ? 5'h1f : lfsr[4:0];
         p = (k % 6 == 0) ? 5'h00 : lfsr[9:5];
         m.xfer({3'b100, r}, 8, rx);
         if (k == 0) check(rx, 8'h61);
         chi = p;
         repeat (2) @(posedge clk);
         #1 check({3'h0, cho}, {3'h0, exp_ch(md, r, p)});
      end
      m.xfer(8'he2, 8, rx);
      check(rx, {3'b000, r});
      check({6'h00, stb, ctl}, 8'h02);
      check(8'(n_thc), 8'h01);
      check({3'h0, cho}, {3'h0, chi});
      m.xfer(8'h60, 8, rx);
      check(rx, 8'h80);
      finish_test();
   end
endmodule
`default_nettype wire
